// >>> verif/fsw_host_model.sv
`timescale 1ns/10ps
module fsw_host_model
(
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe_n
);
    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    // ----------------------------------------
    // One frame, mode 0, 200 ns link clock
    // ----------------------------------------
    // Clock stands still between frames; si flips once released
    task automatic xfer(input logic [31:0] data, input int nbytes,
                        output logic [7:0] rd, output logic drove);
        rd    = 8'h00;
        drove = 1'b0;
        #7;
        cs_n = 1'b0;
        for (int i = 0; i < nbytes * 8; i++)
        begin
            si = data[31 - i];
            #100;
            sck = 1'b1;
            rd  = {rd[6:0], so};
            if (i >= 8 && so_oe_n === 1'b0)
                drove = 1'b1;
            #100;
            sck = 1'b0;
        end
        #100;
        cs_n = 1'b1;
        si   = ~si;
        // Gap of 12 cycles keeps frames apart
        #300;
    endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb
    import fsw_pkg::*;
;
    localparam time SKEW = 2;

    logic       clk;
    logic       rst_n;
    logic       wp_n;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       so;
    logic       so_oe_n;
    logic [7:0] status;
    logic       side_sel;
    logic       quad_pins_en;
    logic [7:0] rd;
    logic       drove;
    int         num_errors;
    int         num_checks;
    int         blk;
    // First seven and last two take an address
    logic [7:0] ops [13] = '{CMD_PAGE_WR, CMD_QPAGE_WR_A, CMD_QPAGE_WR_B, CMD_SECT_ER_A,
                             CMD_SECT_ER_B, CMD_HALF_BLK_ER, CMD_FULL_BLK_ER, CMD_ALL_ER_A,
                             CMD_ALL_ER_B, CMD_STATUS_WR, CMD_FUNC_WR, CMD_INFO_ER,
                             CMD_INFO_WR};

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Long busy so a frame fits inside it
    fsw_status_wp #(.BUSY_CYC(400)) DUT (
        .clk          (clk),
        .rst_n        (rst_n),
        .cs_n         (cs_n),
        .sck          (sck),
        .si           (si),
        .wp_n         (wp_n),
        .so           (so),
        .so_oe_n      (so_oe_n),
        .status       (status),
        .side_sel     (side_sel),
        .quad_pins_en (quad_pins_en)
    );

    fsw_host_model host (
        .cs_n    (cs_n),
        .sck     (sck),
        .si      (si),
        .so      (so),
        .so_oe_n (so_oe_n)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic frame(input logic [31:0] data, input int nbytes);
        host.xfer(data, nbytes, rd, drove);
        @(posedge clk);
        #SKEW;
    endtask

    // Busy must show within 22 cycles and end within the bound
    task automatic settle(input logic exp_busy, input logic exp_latch);
        logic seen;
        int   i;
        seen = 1'b0;
        for (i = 0; i < 600; i++)
        begin
            @(posedge clk);
            #SKEW;
            if (status[0] === 1'b1)
                seen = 1'b1;
            else if (seen || i > 20)
                break;
        end
        if (i == 600)
        begin
            num_errors++;
            $display("[FAIL] %0t ns: busy never ended", $time);
            complete_run();
        end
        else
        begin
            check({7'h00, seen}, {7'h00, exp_busy});
            check({7'h00, status[1]}, {7'h00, exp_latch});
        end
    endtask

    task automatic wr(input logic [31:0] data, input int nbytes, input logic exp_busy);
        frame({CMD_SET_LATCH, 24'h000000}, 1);
        check({7'h00, status[1]}, 8'h01);
        frame(data, nbytes);
        settle(exp_busy, ~exp_busy);
    endtask

    task automatic sw(input logic [7:0] val, input logic exp_busy);
        wr({CMD_STATUS_WR, val, 16'h0000}, 2, exp_busy);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        num_errors = 0;
        num_checks = 0;
        rst_n      = 1'b0;
        wp_n       = 1'b1;
        repeat (6) @(posedge clk);
        #SKEW;
        rst_n = 1'b1;
        repeat (10) @(posedge clk);
        #SKEW;
        check(status, 8'h00);
        check({6'h00, side_sel, quad_pins_en}, 8'h00);
        frame({CMD_STATUS_RD, 24'h000000}, 2);
        check(rd, 8'h00);
        check({7'h00, drove}, 8'h01);
        $display("Test reset done");

        frame({CMD_SET_LATCH, 24'h000000}, 1);
        check(status, 8'h02);
        frame({CMD_CLR_LATCH, 24'h000000}, 1);
        check(status, 8'h00);
        for (int k = 0; k < 13; k++)
        begin
            frame({ops[k], 24'h100000}, 4);
            settle(1'b0, 1'b0);
        end
        $display("Test latch done");

        // Top side: first protected block and its neighbour
        for (int f = 0; f <= 8; f++)
        begin
            sw({2'b00, f[3:0], 2'b11}, 1'b1);
            check(status, {2'b00, f[3:0], 2'b00});
            blk = (f == 0) ? 128 : ((f >= 8) ? 0 : 128 - (1 << (f - 1)));
            if (blk < 128)
                wr({ops[f % 7], 1'b0, blk[6:0], 16'h0000}, 4, 1'b0);
            if (blk > 0)
                wr({ops[(f + 1) % 7], 1'b0, blk[6:0] - 7'h01, 16'h0000}, 4, 1'b1);
        end
        $display("Test top area done");

        wr({CMD_ALL_ER_A, 24'h000000}, 1, 1'b0);
        sw(8'h04, 1'b1);
        wr({CMD_ALL_ER_B, 24'h000000}, 1, 1'b0);
        sw(8'h00, 1'b1);
        wr({CMD_ALL_ER_B, 24'h000000}, 1, 1'b1);
        wr({CMD_ALL_ER_A, 24'h000000}, 1, 1'b1);
        wr({CMD_INFO_ER, 24'h000000}, 4, 1'b1);
        // Frame carries only 32 bits: command and three address bytes
        wr({CMD_INFO_WR, 24'h000000}, 4, 1'b1);
        $display("Test erase done");

        // Second write and a read both land inside the busy time
        frame({CMD_SET_LATCH, 24'h000000}, 1);
        frame({CMD_STATUS_WR, 8'h08, 16'h0000}, 2);
        frame({CMD_STATUS_WR, 8'h30, 16'h0000}, 2);
        frame({CMD_STATUS_RD, 24'h000000}, 2);
        check(rd, 8'h0b);
        settle(1'b1, 1'b0);
        check(status, 8'h08);
        $display("Test busy done");

        sw(8'h80, 1'b1);
        wp_n = 1'b0;
        sw(8'h84, 1'b0);
        check(status, 8'h82);
        wp_n = 1'b1;
        sw(8'hc0, 1'b1);
        check({status[7:0]}, 8'hc0);
        check({7'h00, quad_pins_en}, 8'h01);
        wp_n = 1'b0;
        // Quad on: pin is a data line, so the write goes through
        sw(8'h00, 1'b1);
        // Quad left off for the rest of the run
        check({7'h00, quad_pins_en}, 8'h00);
        wp_n = 1'b1;
        $display("Test lock done");

        wr({CMD_FUNC_WR, 8'h02, 16'h0000}, 2, 1'b1);
        check({7'h00, side_sel}, 8'h01);
        wr({CMD_FUNC_WR, 8'h00, 16'h0000}, 2, 1'b1);
        check({7'h00, side_sel}, 8'h01);
        sw(8'h0f, 1'b1);
        wr({CMD_SECT_ER_B, 8'h03, 16'h0000}, 4, 1'b0);
        wr({CMD_SECT_ER_B, 8'h04, 16'h0000}, 4, 1'b1);
        $display("Test bottom area done");
        complete_run();
    end
endmodule

// >>> verilog/fsw_pkg.sv
// How it works
// - Busy bit0 reads 1 during operations
// - Idle device accepts writes, programs, erases
// - Set-latch command sets latch bit1
// - Clear-latch command clears the latch
// - Latch clears when an operation completes
// - Status write clears the latch when it completes
// - Listed write commands need the latch set
// - Protect, quad, lock bits: status-write only
// - Field n protects 2^(n-1) top/bottom blocks
// - Field top bit protects all blocks
// - Writes into protected area are inhibited
// - Whole erase needs protect field zero
// - Lock plus low protect pin freezes status
// - Otherwise status write updates the register
// - Quad enable turns control pins into data
// - Status read returns all eight bits
// - Side select sets once, clears only on reset
package fsw_pkg;

    // ----------------------------------------
    // Commands
    // ----------------------------------------
    localparam logic [7:0] CMD_PAGE_WR     = 8'h02;
    localparam logic [7:0] CMD_QPAGE_WR_A  = 8'h32;
    localparam logic [7:0] CMD_QPAGE_WR_B  = 8'h38;
    localparam logic [7:0] CMD_SECT_ER_A   = 8'hd7;
    localparam logic [7:0] CMD_SECT_ER_B   = 8'h20;
    localparam logic [7:0] CMD_HALF_BLK_ER = 8'h52;
    localparam logic [7:0] CMD_FULL_BLK_ER = 8'hd8;
    localparam logic [7:0] CMD_ALL_ER_A    = 8'hc7;
    localparam logic [7:0] CMD_ALL_ER_B    = 8'h60;
    localparam logic [7:0] CMD_STATUS_WR   = 8'h01;
    localparam logic [7:0] CMD_FUNC_WR     = 8'h42;
    localparam logic [7:0] CMD_INFO_ER     = 8'h64;
    localparam logic [7:0] CMD_INFO_WR     = 8'h62;
    localparam logic [7:0] CMD_STATUS_RD   = 8'h05;
    localparam logic [7:0] CMD_SET_LATCH   = 8'h06;
    localparam logic [7:0] CMD_CLR_LATCH   = 8'h04;

    // ----------------------------------------
    // Layout and timing
    // ----------------------------------------
    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam logic [1:0] ADDR_LAST    = 2'h2;
    localparam int         BLK_LO       = 16;
    localparam int         BLK_W        = 7;
    localparam int         SIDE_BIT     = 1;
    localparam int         BUSY_CYC_DEF = 1000;

    typedef struct packed {
        logic       lock;
        logic       quad_en;
        logic [3:0] prot;
        logic       write_enable_latch;
        logic       busy;
    } fsw_status_s;

    localparam fsw_status_s STATUS_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_CMD,
        ST_ADDR,
        ST_DATA,
        ST_STAT,
        ST_SKIP
    } fsw_state_e;

endpackage

// >>> verilog/fsw_protect_chk.sv
`timescale 1ns/10ps
module fsw_protect_chk
    import fsw_pkg::*;
#(
    parameter int BW = BLK_W
)(
    input  wire logic [3:0]    prot,
    input  wire logic          side,
    input  wire logic [BW-1:0] blk,
    output logic               hit
);

    // ----------------------------------------
    // Protected area decode
    // ----------------------------------------
    logic [BW:0] cnt;
    logic [BW:0] nblk;
    logic [BW:0] b;

    always_comb
    begin
        nblk = {1'b1, {BW{1'b0}}};
        b    = {1'b0, blk};
        cnt  = '0;
        if (prot[2:0] != 3'h0)
        begin
            cnt = (BW+1)'(1) << (prot[2:0] - 3'h1);
        end
        if (prot[3])
        begin
            hit = 1'b1;
        end
        else if (side)
        begin
            hit = b < cnt;
        end
        else
        begin
            hit = (cnt != '0) && (b >= nblk - cnt);
        end
    end

endmodule

// >>> verilog/fsw_status_wp.sv
`timescale 1ns/10ps
module fsw_status_wp
    import fsw_pkg::*;
#(
    parameter int BUSY_CYC = BUSY_CYC_DEF
)(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       si,
    input  wire logic       wp_n,
    output logic            so,
    output logic            so_oe_n,
    output logic [7:0]      status,
    output logic            side_sel,
    output logic            quad_pins_en
);

    // ----------------------------------------
    // Reset and pin synchronisers
    // ----------------------------------------
    logic [1:0] rst_ff;
    logic [1:0] nxt_rst;
    logic [2:0] sck_ff;
    logic [2:0] nxt_sck;
    logic [2:0] cs_ff;
    logic [2:0] nxt_cs;
    logic [1:0] si_ff;
    logic [1:0] nxt_si;
    logic [1:0] wp_ff;
    logic [1:0] nxt_wp;
    logic       rst_sync_n;

    assign rst_sync_n = rst_ff[1];

    always_comb
    begin
        nxt_rst = {rst_ff[0], 1'b1};
        nxt_sck = {sck_ff[1:0], sck};
        nxt_cs  = {cs_ff[1:0], cs_n};
        nxt_si  = {si_ff[0], si};
        nxt_wp  = {wp_ff[0], wp_n};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_ff <= 2'h0;
        end
        else
        begin
            rst_ff <= nxt_rst;
        end
    end

    // Idle levels: clock low, select high, protect pin high
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sck_ff <= 3'h0;
            cs_ff  <= 3'h7;
            si_ff  <= 2'h0;
            wp_ff  <= 2'h3;
        end
        else
        begin
            sck_ff <= nxt_sck;
            cs_ff  <= nxt_cs;
            si_ff  <= nxt_si;
            wp_ff  <= nxt_wp;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cs_hi;
    logic frame_end;

    assign sck_rise  = sck_ff[1] & ~sck_ff[2];
    assign sck_fall  = ~sck_ff[1] & sck_ff[2];
    assign cs_hi     = cs_ff[1];
    assign frame_end = cs_ff[1] & ~cs_ff[2];

    // ----------------------------------------
    // Command decode helpers
    // ----------------------------------------
    function automatic logic needs_addr(input logic [7:0] c);
        needs_addr = (c == CMD_PAGE_WR) || (c == CMD_QPAGE_WR_A) ||
                     (c == CMD_QPAGE_WR_B) || (c == CMD_SECT_ER_A) ||
                     (c == CMD_SECT_ER_B) || (c == CMD_HALF_BLK_ER) ||
                     (c == CMD_FULL_BLK_ER) || (c == CMD_INFO_ER) ||
                     (c == CMD_INFO_WR);
    endfunction

    function automatic logic is_info(input logic [7:0] c);
        is_info = (c == CMD_INFO_ER) || (c == CMD_INFO_WR);
    endfunction

    function automatic logic is_all_er(input logic [7:0] c);
        is_all_er = (c == CMD_ALL_ER_A) || (c == CMD_ALL_ER_B);
    endfunction

    // ----------------------------------------
    // Serial frame
    // ----------------------------------------
    fsw_state_e  st_ff;
    fsw_state_e  nxt_st;
    logic [2:0]  bit_cnt_ff;
    logic [2:0]  nxt_bit_cnt;
    logic [1:0]  byte_cnt_ff;
    logic [1:0]  nxt_byte_cnt;
    logic [6:0]  shift_ff;
    logic [6:0]  nxt_shift;
    logic [7:0]  cmd_ff;
    logic [7:0]  nxt_cmd;
    logic [23:0] addr_ff;
    logic [23:0] nxt_addr;
    logic [7:0]  data_ff;
    logic [7:0]  nxt_data;
    logic        cmd_ok_ff;
    logic        nxt_cmd_ok;
    logic        addr_ok_ff;
    logic        nxt_addr_ok;
    logic        data_ok_ff;
    logic        nxt_data_ok;
    logic        so_ff;
    logic        nxt_so;
    logic        so_oe_n_ff;
    logic        nxt_so_oe_n;
    logic [7:0]  rx_byte;
    fsw_status_s status_ff;

    assign rx_byte = {shift_ff, si_ff[1]};

    always_comb
    begin
        nxt_st       = st_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_byte_cnt = byte_cnt_ff;
        nxt_shift    = shift_ff;
        nxt_cmd      = cmd_ff;
        nxt_addr     = addr_ff;
        nxt_data     = data_ff;
        nxt_cmd_ok   = cmd_ok_ff;
        nxt_addr_ok  = addr_ok_ff;
        nxt_data_ok  = data_ok_ff;
        nxt_so       = so_ff;
        nxt_so_oe_n  = so_oe_n_ff;
        if (cs_hi)
        begin
            nxt_st       = ST_CMD;
            nxt_bit_cnt  = 3'h0;
            nxt_byte_cnt = 2'h0;
            nxt_so_oe_n  = 1'b1;
            if (!frame_end)
            begin
                nxt_cmd_ok  = 1'b0;
                nxt_addr_ok = 1'b0;
                nxt_data_ok = 1'b0;
            end
        end
        else if (sck_rise)
        begin
            nxt_shift   = rx_byte[6:0];
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == BIT_LAST)
            begin
                unique case (st_ff)
                    ST_CMD:
                    begin
                        nxt_cmd    = rx_byte;
                        nxt_cmd_ok = 1'b1;
                        if (rx_byte == CMD_STATUS_RD)
                        begin
                            nxt_st = ST_STAT;
                        end
                        else if (needs_addr(rx_byte))
                        begin
                            nxt_st = ST_ADDR;
                        end
                        else if ((rx_byte == CMD_STATUS_WR) || (rx_byte == CMD_FUNC_WR))
                        begin
                            nxt_st = ST_DATA;
                        end
                        else
                        begin
                            nxt_st = ST_SKIP;
                        end
                    end
                    ST_ADDR:
                    begin
                        nxt_addr     = {addr_ff[15:0], rx_byte};
                        nxt_byte_cnt = byte_cnt_ff + 2'h1;
                        if (byte_cnt_ff == ADDR_LAST)
                        begin
                            nxt_addr_ok = 1'b1;
                            nxt_st      = ST_SKIP;
                        end
                    end
                    ST_DATA:
                    begin
                        nxt_data    = rx_byte;
                        nxt_data_ok = 1'b1;
                        nxt_st      = ST_SKIP;
                    end
                    ST_STAT, ST_SKIP:
                    begin
                        nxt_st = st_ff;
                    end
                endcase
            end
        end
        else if (sck_fall && (st_ff == ST_STAT))
        begin
            // Live value, so polling sees busy drop mid-frame
            nxt_so      = status_ff[BIT_LAST - bit_cnt_ff];
            nxt_so_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st_ff       <= ST_CMD;
            bit_cnt_ff  <= 3'h0;
            byte_cnt_ff <= 2'h0;
            shift_ff    <= 7'h00;
            cmd_ff      <= 8'h00;
            addr_ff     <= 24'h000000;
            data_ff     <= 8'h00;
            cmd_ok_ff   <= 1'b0;
            addr_ok_ff  <= 1'b0;
            data_ok_ff  <= 1'b0;
            so_ff       <= 1'b0;
            so_oe_n_ff  <= 1'b1;
        end
        else
        begin
            st_ff       <= nxt_st;
            bit_cnt_ff  <= nxt_bit_cnt;
            byte_cnt_ff <= nxt_byte_cnt;
            shift_ff    <= nxt_shift;
            cmd_ff      <= nxt_cmd;
            addr_ff     <= nxt_addr;
            data_ff     <= nxt_data;
            cmd_ok_ff   <= nxt_cmd_ok;
            addr_ok_ff  <= nxt_addr_ok;
            data_ok_ff  <= nxt_data_ok;
            so_ff       <= nxt_so;
            so_oe_n_ff  <= nxt_so_oe_n;
        end
    end

    // ----------------------------------------
    // Status, protection and busy timer
    // ----------------------------------------
    logic        hit;
    logic        go;
    logic        wp_low;
    logic        locked;
    logic        start;
    logic        side_ff;
    logic        nxt_side;
    logic [31:0] busy_cnt_ff;
    logic [31:0] nxt_busy_cnt;
    fsw_status_s nxt_status;

    fsw_protect_chk #(
        .BW   (BLK_W)
    ) u_prot (
        .prot (status_ff.prot),
        .side (side_ff),
        .blk  (addr_ff[BLK_LO +: BLK_W]),
        .hit  (hit)
    );

    assign go     = frame_end & cmd_ok_ff;
    assign wp_low = ~status_ff.quad_en & ~wp_ff[1];
    assign locked = status_ff.lock & wp_low;

    always_comb
    begin
        nxt_status   = status_ff;
        nxt_side     = side_ff;
        nxt_busy_cnt = busy_cnt_ff;
        start        = 1'b0;
        // Writes only while idle and latched
        if (go && !status_ff.busy)
        begin
            if (cmd_ff == CMD_SET_LATCH)
            begin
                nxt_status.write_enable_latch = 1'b1;
            end
            else if (cmd_ff == CMD_CLR_LATCH)
            begin
                nxt_status.write_enable_latch = 1'b0;
            end
            else if (status_ff.write_enable_latch)
            begin
                if ((cmd_ff == CMD_STATUS_WR) && data_ok_ff && !locked)
                begin
                    start              = 1'b1;
                    nxt_status.lock    = data_ff[7];
                    nxt_status.quad_en = data_ff[6];
                    nxt_status.prot    = data_ff[5:2];
                end
                else if ((cmd_ff == CMD_FUNC_WR) && data_ok_ff)
                begin
                    start    = 1'b1;
                    nxt_side = side_ff | data_ff[SIDE_BIT];
                end
                else if (is_all_er(cmd_ff) && (status_ff.prot == 4'h0))
                begin
                    start = 1'b1;
                end
                else if (needs_addr(cmd_ff) && addr_ok_ff && (!hit || is_info(cmd_ff)))
                begin
                    start = 1'b1;
                end
            end
        end
        if (start)
        begin
            nxt_status.busy = 1'b1;
            nxt_busy_cnt    = 32'(BUSY_CYC - 1);
        end
        else if (status_ff.busy)
        begin
            if (busy_cnt_ff == 32'h0)
            begin
                nxt_status.busy = 1'b0;
                nxt_status.write_enable_latch  = 1'b0;
            end
            else
            begin
                nxt_busy_cnt = busy_cnt_ff - 32'h1;
            end
        end
    end

    // Non-volatile bits reload factory zeros on reset
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            status_ff   <= STATUS_RST;
            side_ff     <= 1'b0;
            busy_cnt_ff <= 32'h0;
        end
        else
        begin
            status_ff   <= nxt_status;
            side_ff     <= nxt_side;
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign so           = so_ff;
    assign so_oe_n      = so_oe_n_ff;
    assign status       = status_ff;
    assign side_sel     = side_ff;
    assign quad_pins_en = status_ff.quad_en;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_busy_len:
    assert property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(status_ff.busy) |-> status_ff.busy[*8])
    else $error("busy dropped early");

    a_set_latch:
    assert property (@(posedge clk) disable iff (!rst_sync_n)
        go && !status_ff.busy && (cmd_ff == CMD_SET_LATCH) |=> status_ff.write_enable_latch)
    else $error("set-latch ignored");

    a_clr_latch:
    assert property (@(posedge clk) disable iff (!rst_sync_n)
        go && !status_ff.busy && (cmd_ff == CMD_CLR_LATCH) |=> !status_ff.write_enable_latch)
    else $error("clear-latch ignored");

    a_done_clears:
    assert property (@(posedge clk) disable iff (!rst_sync_n)
        $fell(status_ff.busy) |-> !status_ff.write_enable_latch)
    else $error("latch left set after op");

    a_start_latch:
    assert property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(status_ff.busy) |-> $past(status_ff.write_enable_latch) && status_ff.write_enable_latch)
    else $error("op started without latch");

    a_prot_block:
    assert property (@(posedge clk) disable iff (!rst_sync_n)
        go && hit && needs_addr(cmd_ff) && !is_info(cmd_ff) |=> !$rose(status_ff.busy))
    else $error("protected area written");

    a_erase_all:
    assert property (@(posedge clk) disable iff (!rst_sync_n)
        go && is_all_er(cmd_ff) && (status_ff.prot != 4'h0) |=> !$rose(status_ff.busy))
    else $error("whole erase not blocked");

    a_lock_hold:
    assert property (@(posedge clk) disable iff (!rst_sync_n)
        go && locked && (cmd_ff == CMD_STATUS_WR) |=> $stable(status_ff[7:2]))
    else $error("locked status changed");

    a_side_once:
    assert property (@(posedge clk) disable iff (!rst_sync_n)
        side_ff |=> side_ff)
    else $error("side select cleared");

    a_busy_ignore:
    assert property (@(posedge clk) disable iff (!rst_sync_n)
        // Last busy cycle excluded: latch clears there by design
        go && status_ff.busy && (busy_cnt_ff != 32'h0) |=> $stable(status_ff[7:1]))
    else $error("write taken while busy");

endmodule
